//--- osc_clock_ctl.sv
`timescale 1ns/10ps
module osc_clock_ctl import osc_ctl_pkg::*; #(
	parameter int PLL_SETTLE_CNT = PLL_SETTLE_CYCLES,
	parameter int USB_SETTLE_CNT = PLL_SETTLE_CYCLES,
	parameter int LSO_WARMUP = LSO_WARMUP_CYCLES
) (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic SRST,
	// Control register access
	input wire bus_wr_t KEY_WR,
	input wire bus_wr_t CTL_WR,
	output logic [CTL_W-1:0] OSC_CONTROL_REG,
	output logic CTL_WR_IGNORED,
	// Fast RC trim
	input wire logic TRIM_WR,
	input wire logic [TRIM_W-1:0] TRIM_DATA,
	output logic [TRIM_W-1:0] FAST_RC_TRIM_REG,
	// Configuration and power-up status
	input wire cfg_t CFG,
	input wire logic POWER_UP_TIMER_DONE,
	// Low speed crystal oscillator
	input wire logic LSO_CLK_PIN,
	output logic LSO_RUN,
	output logic LSO_PINS_OWNED,
	// Fast RC and low power RC
	output logic FAST_RC_POSTSCALE_MODE,
	output logic FAST_RC_MULTIPLIED_MODE,
	output logic [8:0] FAST_RC_DIVISOR,
	output logic [2:0] PLL_IN_DIV,
	output logic LOW_POWER_RC_ON,
	// Peripheral bus
	input wire logic PB_ACCESS,
	output logic PB_CLK_EN,
	output logic CPU_STALL
);

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (SRST);

	localparam int PCW = $clog2(PLL_SETTLE_CNT + 1);
	localparam int UCW = $clog2(USB_SETTLE_CNT + 1);
	localparam int LCW = $clog2(LSO_WARMUP + 1);

	unlock_state_t unlock_state;
	logic wr_ok;
	logic lso_sw_en;
	logic [2:0] frc_div;
	logic [2:0] cur_src;
	logic [1:0] pb_div_req;
	logic [1:0] pb_div;
	logic [2:0] pb_cnt;
	logic pb_tick;
	logic pb_busy;
	logic switch_to_pll;
	logic src_pll;
	logic [PCW-1:0] pll_cnt;
	logic pll_lock;
	logic [UCW-1:0] usb_cnt;
	logic usb_done;
	logic usb_lock;
	logic lso_meta;
	logic lso_sync;
	logic lso_prev;
	logic lso_edge;
	logic lso_on;
	logic [LCW-1:0] lso_cnt;
	logic lso_rdy;

	function automatic logic uses_pll(input logic [2:0] src);
		return (src == SRC_FRC_PLL) || (src == SRC_PRI_PLL);
	endfunction : uses_pll

	function automatic logic [8:0] frc_divisor(input logic [2:0] code);
		if (code == 3'h0) begin
			return 9'h001;
		end else if (code == 3'h7) begin
			return 9'h100;
		end
		return 9'(9'h001 << code);
	endfunction : frc_divisor

	// Unlock: two keys back to back open exactly one control write
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			unlock_state <= UL_LOCKED;
		end else if (CTL_WR.strobe) begin
			unlock_state <= UL_LOCKED;
		end else if (KEY_WR.strobe) begin
			unique case (unlock_state)
				UL_LOCKED: begin
					unlock_state <= (KEY_WR.data == UNLOCK_KEY1) ? UL_KEY1 : UL_LOCKED;
				end
				UL_KEY1: begin
					unlock_state <= (KEY_WR.data == UNLOCK_KEY2) ? UL_OPEN : UL_LOCKED;
				end
				UL_OPEN: begin
					unlock_state <= UL_LOCKED;
				end
			endcase
		end
	end

	assign wr_ok = CTL_WR.strobe && (unlock_state == UL_OPEN);

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			CTL_WR_IGNORED <= 1'b0;
		end else begin
			CTL_WR_IGNORED <= CTL_WR.strobe && (unlock_state != UL_OPEN);
		end
	end

	// Control fields
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			lso_sw_en <= 1'b0;
			frc_div <= FRC_DIV_RST;
			pb_div_req <= PB_DIV_RST;
			cur_src <= CUR_SRC_RST;
		end else if (wr_ok) begin
			lso_sw_en <= CFG.lso_hw_en & CTL_WR.data[LSO_SW_EN_BIT];
			frc_div <= CTL_WR.data[FRC_DIV_LSB +: 3];
			pb_div_req <= CTL_WR.data[PB_DIV_LSB +: 2];
			if (CTL_WR.data[SWITCH_BIT]) begin
				cur_src <= CTL_WR.data[NEW_SRC_LSB +: 3];
			end
		end
	end

	assign switch_to_pll = wr_ok && CTL_WR.data[SWITCH_BIT]
		&& uses_pll(CTL_WR.data[NEW_SRC_LSB +: 3]);
	assign src_pll = uses_pll(cur_src);

	// PLL settle timer; it does not see a real loss of lock
	always_ff @(posedge CORE_CLK) begin
		if (SRST || switch_to_pll || !src_pll) begin
			pll_cnt <= '0;
			pll_lock <= 1'b0;
		end else if (!pll_lock) begin
			if (pll_cnt == PCW'(PLL_SETTLE_CNT - 1)) begin
				pll_lock <= 1'b1;
			end else begin
				pll_cnt <= pll_cnt + 1'b1;
			end
		end
	end

	property p_pll_clear;
		!src_pll |=> !pll_lock;
	endproperty
	a_pll_clear: assert property (p_pll_clear) else $error("PLL flag set without PLL source");

	property p_pll_set;
		$rose(pll_lock) |-> $past(pll_cnt) == PCW'(PLL_SETTLE_CNT - 1) && $past(src_pll);
	endproperty
	a_pll_set: assert property (p_pll_set) else $error("PLL flag set before settle time");

	// USB PLL timer runs from reset; the flag is masked without a PLL source
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			usb_cnt <= '0;
			usb_done <= 1'b0;
		end else if (!usb_done) begin
			if (usb_cnt == UCW'(USB_SETTLE_CNT - 1)) begin
				usb_done <= 1'b1;
			end else begin
				usb_cnt <= usb_cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST || !src_pll) begin
			usb_lock <= 1'b0;
		end else begin
			usb_lock <= usb_done;
		end
	end

	property p_usb_clear;
		usb_lock |-> $past(src_pll) && $past(usb_done);
	endproperty
	a_usb_clear: assert property (p_usb_clear) else $error("USB flag set without cause");

	// Low speed oscillator clock: two flops before any edge logic
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			lso_meta <= 1'b0;
			lso_sync <= 1'b0;
			lso_prev <= 1'b0;
		end else begin
			lso_meta <= LSO_CLK_PIN;
			lso_sync <= lso_meta;
			lso_prev <= lso_sync;
		end
	end

	assign lso_edge = lso_sync & ~lso_prev;
	assign lso_on = lso_sw_en & CFG.lso_hw_en;

	// Warm-up restarts from zero whenever the oscillator is turned off
	always_ff @(posedge CORE_CLK) begin
		if (SRST || !lso_on) begin
			lso_cnt <= '0;
			lso_rdy <= 1'b0;
		end else if (lso_edge && !lso_rdy) begin
			if (lso_cnt == LCW'(LSO_WARMUP - 1)) begin
				lso_rdy <= 1'b1;
			end else begin
				lso_cnt <= lso_cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			LSO_RUN <= 1'b0;
			LSO_PINS_OWNED <= 1'b0;
		end else begin
			LSO_RUN <= lso_on;
			LSO_PINS_OWNED <= lso_on;
		end
	end

	property p_lso_rdy;
		$rose(lso_rdy) |-> $past(lso_cnt) == LCW'(LSO_WARMUP - 1) && $past(lso_edge);
	endproperty
	a_lso_rdy: assert property (p_lso_rdy) else $error("Low speed ready too early");

	property p_lso_pins;
		lso_on ##1 lso_on |-> LSO_PINS_OWNED && LSO_RUN;
	endproperty
	a_lso_pins: assert property (p_lso_pins) else $error("Crystal pins not held by oscillator");

	property p_unlock;
		CTL_WR.strobe && unlock_state != UL_OPEN |=> $stable(cur_src) && $stable(pb_div_req)
			&& $stable(frc_div) && $stable(lso_sw_en);
	endproperty
	a_unlock: assert property (p_unlock) else $error("Locked write changed control");

	// Fast RC modes and PLL input divider
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			FAST_RC_POSTSCALE_MODE <= 1'b0;
			FAST_RC_MULTIPLIED_MODE <= 1'b0;
			FAST_RC_DIVISOR <= 9'h001;
			PLL_IN_DIV <= PLL_IDIV_BY2;
		end else begin
			FAST_RC_POSTSCALE_MODE <= (cur_src == SRC_FRC_DIV);
			FAST_RC_MULTIPLIED_MODE <= (cur_src == SRC_FRC_PLL);
			FAST_RC_DIVISOR <= frc_divisor(frc_div);
			PLL_IN_DIV <= (cur_src == SRC_FRC_PLL) ? PLL_IDIV_BY2 : CFG.pll_in_div;
		end
	end

	property p_force_div;
		cur_src == SRC_FRC_PLL ##1 cur_src == SRC_FRC_PLL |-> PLL_IN_DIV == PLL_IDIV_BY2;
	endproperty
	a_force_div: assert property (p_force_div) else $error("PLL input divider not forced");

	// Trim goes straight to the oscillator; one code step is one frequency step
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			FAST_RC_TRIM_REG <= TRIM_RST;
		end else if (TRIM_WR) begin
			FAST_RC_TRIM_REG <= TRIM_DATA;
		end
	end

	// Low power RC enable; sync reset may sample the regulator strap
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			LOW_POWER_RC_ON <= !CFG.regulator_en;
		end else if (POWER_UP_TIMER_DONE) begin
			LOW_POWER_RC_ON <= CFG.fail_safe_en || CFG.watchdog_en
				|| (cur_src == SRC_LOW_POWER_RC);
		end else begin
			LOW_POWER_RC_ON <= !CFG.regulator_en;
		end
	end

	property p_low_power_rc_keep;
		POWER_UP_TIMER_DONE && (CFG.watchdog_en || CFG.fail_safe_en) |=> LOW_POWER_RC_ON;
	endproperty
	a_low_power_rc_keep: assert property (p_low_power_rc_keep) else $error("Low power RC dropped while needed");

	// Peripheral bus divider; system clock logic never sees the ratio
	assign pb_tick = (pb_cnt == 3'((4'h1 << pb_div) - 4'h1));
	assign PB_CLK_EN = pb_tick;

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			pb_cnt <= 3'h0;
			pb_div <= PB_DIV_RST;
		end else if (pb_tick) begin
			pb_cnt <= 3'h0;
			pb_div <= pb_div_req;
		end else begin
			pb_cnt <= pb_cnt + 3'h1;
		end
	end

	property p_pb_div1;
		pb_div == 2'h0 |-> PB_CLK_EN;
	endproperty
	a_pb_div1: assert property (p_pb_div1) else $error("Bus clock slower at divisor one");

	property p_pb_div2;
		pb_div == 2'h1 && PB_CLK_EN && pb_div_req == 2'h1 |=> !PB_CLK_EN ##1 PB_CLK_EN;
	endproperty
	a_pb_div2: assert property (p_pb_div2) else $error("Divide-by-2 spacing wrong");

	property p_pb_switch;
		!pb_tick |=> $stable(pb_div);
	endproperty
	a_pb_switch: assert property (p_pb_switch) else $error("Bus divisor changed mid period");

	// Access busy until the next bus edge; a new access wins over the clear
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			pb_busy <= 1'b0;
		end else if (PB_ACCESS && !CPU_STALL && pb_div != 2'h0) begin
			pb_busy <= 1'b1;
		end else if (pb_tick) begin
			pb_busy <= 1'b0;
		end
	end

	assign CPU_STALL = PB_ACCESS && pb_busy;

	property p_stall;
		CPU_STALL |-> $past(pb_div) != 2'h0 || pb_div != 2'h0;
	endproperty
	a_stall: assert property (p_stall) else $error("Stall at divisor one");

	// Read image
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			OSC_CONTROL_REG <= '0;
		end else begin
			OSC_CONTROL_REG <= '0;
			OSC_CONTROL_REG[LSO_SW_EN_BIT] <= lso_sw_en;
			OSC_CONTROL_REG[PLL_LOCK_BIT] <= pll_lock;
			OSC_CONTROL_REG[USB_LOCK_BIT] <= usb_lock;
			OSC_CONTROL_REG[CUR_SRC_LSB +: 3] <= cur_src;
			OSC_CONTROL_REG[PB_DIV_LSB +: 2] <= pb_div_req;
			OSC_CONTROL_REG[LSO_RDY_BIT] <= lso_rdy;
			OSC_CONTROL_REG[FRC_DIV_LSB +: 3] <= frc_div;
		end
	end

endmodule : osc_clock_ctl

//--- osc_ctl_pkg.sv
// Summary of operation
// - Read-only PLL settled flag at bit 5, set after the settle delay.
// - PLL settled flag cleared at reset, on switch to PLL source, held clear without a PLL source.
// - Read-only USB PLL settled flag at bit 6, set after the settle delay.
// - USB PLL settled flag cleared at reset, held clear without a PLL source.
// - Low speed oscillator needs hardware enable; software enable at bit 1 controls it.
// - While software enabled, both crystal pins belong to the oscillator.
// - Low speed oscillator runs continuously while its software enable is set.
// - Warm-up counts 1024 oscillator cycles, then sets ready flag at bit 22.
// - Control register writes without a preceding unlock are ignored.
// - Postscaler field bits 26:24 selects direct, divide-by-2 up to 64, or divide-by-256.
// - Postscaled fast RC mode whenever current source reads 111.
// - Multiplied fast RC mode whenever current source reads 001.
// - Multiplied mode forces the PLL input divider to two.
// - Trim value steps fast RC frequency one fixed amount per unit.
// - With regulator enabled, low power RC starts disabled at reset.
// - After power-up timer, low power RC stays on for monitor, watchdog or source 100.
// - Bus clock is system clock divided by 1, 2, 4 or 8 from bits 20:19.
// - Bus clock never faster than processor clock; equal when divisor is one.
// - With divisor above one, back-to-back bus accesses stall the CPU.
// - Bus divisor changes leave system clock peripherals unaffected.
package osc_ctl_pkg;
	localparam int CTL_W = 32;
	localparam int TRIM_W = 6;
	localparam int SWITCH_BIT = 0;
	localparam int LSO_SW_EN_BIT = 1;
	localparam int PLL_LOCK_BIT = 5;
	localparam int USB_LOCK_BIT = 6;
	localparam int NEW_SRC_LSB = 8;
	localparam int CUR_SRC_LSB = 12;
	localparam int PB_DIV_LSB = 19;
	localparam int LSO_RDY_BIT = 22;
	localparam int FRC_DIV_LSB = 24;
	localparam logic [2:0] SRC_FRC = 3'h0;
	localparam logic [2:0] SRC_FRC_PLL = 3'h1;
	localparam logic [2:0] SRC_PRI_PLL = 3'h3;
	localparam logic [2:0] SRC_LOW_POWER_RC = 3'h4;
	localparam logic [2:0] SRC_FRC_DIV = 3'h7;
	localparam logic [2:0] CUR_SRC_RST = SRC_FRC;
	localparam logic [2:0] FRC_DIV_RST = 3'h0;
	localparam logic [1:0] PB_DIV_RST = 2'h0;
	localparam logic [TRIM_W-1:0] TRIM_RST = 6'h00;
	localparam logic [2:0] PLL_IDIV_BY2 = 3'h1;
	localparam logic [CTL_W-1:0] UNLOCK_KEY1 = 32'h5a5a_0f0f;
	localparam logic [CTL_W-1:0] UNLOCK_KEY2 = 32'ha5a5_f0f0;
	localparam int LSO_WARMUP_CYCLES = 1024;
	localparam int CLK_PERIOD_NS = 20;
	localparam int PLL_SETTLE_TIME_NS = 100000;
	localparam int PLL_SETTLE_CYCLES = (PLL_SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {UL_LOCKED, UL_KEY1, UL_OPEN} unlock_state_t;

	typedef struct packed {
		logic strobe;
		logic [CTL_W-1:0] data;
	} bus_wr_t;

	typedef struct packed {
		logic lso_hw_en;
		logic regulator_en;
		logic fail_safe_en;
		logic watchdog_en;
		logic [2:0] pll_in_div;
	} cfg_t;
endpackage : osc_ctl_pkg

//--- oscillator_status_and_bus_clock_bench.sv
`timescale 1ns/10ps
module oscillator_status_and_bus_clock_bench import osc_ctl_pkg::*;;
	// Short settle and warm-up counts keep the run brief
	localparam int SETTLE = 8;
	localparam int WARM = 4;
	localparam logic [31:0] F_STALL = 32'h01, F_IGN = 32'h02, F_MUL = 32'h04, F_PS = 32'h08;
	localparam logic [31:0] F_PIN = 32'h10, F_RUN = 32'h20, F_LOW_POWER_RC = 32'h40;
	typedef struct {int sel; logic [31:0] mask; logic [31:0] exp;} note_t;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	bus_wr_t key_wr = '0;
	bus_wr_t ctl_wr = '0;
	logic trim_wr = 1'b0;
	logic [TRIM_W-1:0] trim_data = '0;
	cfg_t cfg = '{1'b0, 1'b1, 1'b0, 1'b0, 3'h5};
	logic power_up_timer_done = 1'b0;
	logic lso_clk_pin = 1'b0;
	logic pb_access = 1'b0;
	logic [CTL_W-1:0] osc_control_reg;
	logic ctl_wr_ignored, lso_run, lso_pins_owned, postscale_mode, multiplied_mode;
	logic low_power_rc_on, pb_clk_en, cpu_stall;
	logic [TRIM_W-1:0] trim_reg;
	logic [8:0] fast_rc_divisor;
	logic [2:0] pll_in_div;
	logic [31:0] seed = 32'h0001_1242;
	logic [31:0] rnd;
	int bad_count = 0, tests_run = 0, cycles = 0, run_len = 1, gap = 0;
	note_t notes[$];
	note_t cur;

	osc_clock_ctl #(.PLL_SETTLE_CNT(SETTLE), .USB_SETTLE_CNT(SETTLE), .LSO_WARMUP(WARM)) dut (
		.CORE_CLK(core_clk), .SRST(srst), .KEY_WR(key_wr), .CTL_WR(ctl_wr),
		.OSC_CONTROL_REG(osc_control_reg), .CTL_WR_IGNORED(ctl_wr_ignored),
		.TRIM_WR(trim_wr), .TRIM_DATA(trim_data), .FAST_RC_TRIM_REG(trim_reg),
		.CFG(cfg), .POWER_UP_TIMER_DONE(power_up_timer_done), .LSO_CLK_PIN(lso_clk_pin),
		.LSO_RUN(lso_run), .LSO_PINS_OWNED(lso_pins_owned),
		.FAST_RC_POSTSCALE_MODE(postscale_mode), .FAST_RC_MULTIPLIED_MODE(multiplied_mode),
		.FAST_RC_DIVISOR(fast_rc_divisor), .PLL_IN_DIV(pll_in_div),
		.LOW_POWER_RC_ON(low_power_rc_on), .PB_ACCESS(pb_access), .PB_CLK_EN(pb_clk_en),
		.CPU_STALL(cpu_stall));

	always #10 core_clk = ~core_clk;

	// Bus clock period as seen on the tick output
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (pb_clk_en === 1'b1) begin
			gap <= run_len;
			run_len <= 1;
		end else begin
			run_len <= run_len + 1;
		end
		if (cycles == 4000) begin
			bad_count++;
			$display("MISMATCH at %0t: run did not finish", $time);
			end_of_test();
		end
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	function automatic logic [31:0] seen(input int s);
		case (s)
			0: return osc_control_reg;
			1: return 32'(fast_rc_divisor);
			2: return 32'(pll_in_div);
			3: return {25'h0, low_power_rc_on, lso_run, lso_pins_owned, postscale_mode,
				multiplied_mode, ctl_wr_ignored, cpu_stall};
			4: return 32'(trim_reg);
			default: return 32'(gap);
		endcase
	endfunction : seen

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// Notes are judged at the falling edge, after registered outputs settle
	always @(negedge core_clk) begin
		while (notes.size() > 0) begin
			cur = notes.pop_front();
			check(seen(cur.sel) & cur.mask, cur.exp);
		end
	end

	task automatic note(input int s, input logic [31:0] m, input logic [31:0] e);
		notes.push_back('{s, m, e});
	endtask : note

	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
	endtask : step

	task automatic pulse(input bit key, input logic [31:0] d);
		@(posedge core_clk);
		if (key) key_wr <= '{1'b1, d};
		else ctl_wr <= '{1'b1, d};
		@(posedge core_clk);
		key_wr.strobe <= 1'b0;
		ctl_wr.strobe <= 1'b0;
	endtask : pulse

	task automatic wr_ctl(input logic [2:0] src, input bit lso, input logic [1:0] pb,
		input logic [2:0] ps);
		pulse(1'b1, UNLOCK_KEY1);
		pulse(1'b1, UNLOCK_KEY2);
		pulse(1'b0, (32'(ps) << FRC_DIV_LSB) | (32'(pb) << PB_DIV_LSB) |
			(32'(src) << NEW_SRC_LSB) | (32'(lso) << LSO_SW_EN_BIT) | 32'h1);
		step(2);
	endtask : wr_ctl

	task automatic lso_edges(input int n);
		repeat (n) begin
			step(2);
			lso_clk_pin <= 1'b1;
			step(2);
			lso_clk_pin <= 1'b0;
		end
		step(4);
	endtask : lso_edges

	task automatic end_of_test();
		$display("Counts: %0d compared, %0d mismatched", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_of_test

	initial begin
		step(4);
		srst <= 1'b0;
		note(0, 32'hffff_ffff, 32'h0);
		note(1, 32'h1ff, 32'h1);
		note(3, F_LOW_POWER_RC | F_STALL, 32'h0);
		$display("test reset done");
		pulse(1'b0, 32'h0700_0001);
		note(3, F_IGN, F_IGN);
		// Repeated first key must not open the window
		pulse(1'b1, UNLOCK_KEY1);
		pulse(1'b1, UNLOCK_KEY1);
		pulse(1'b0, 32'h0700_0001);
		note(3, F_IGN, F_IGN);
		step(2);
		note(0, 32'h0700_0000, 32'h0);
		$display("test unlock done");
		for (int i = 0; i < 8; i++) begin
			wr_ctl(SRC_FRC_DIV, 1'b0, 2'h0, 3'(i));
			note(1, 32'h1ff, (i == 7) ? 32'd256 : 32'd1 << i);
			note(0, 32'h0700_7000, (32'(i) << 24) | 32'h7000);
			note(3, F_PS | F_MUL, F_PS);
		end
		$display("test postscale done");
		wr_ctl(SRC_FRC_PLL, 1'b0, 2'h0, 3'h0);
		note(3, F_PS | F_MUL, F_MUL);
		note(2, 32'h7, 32'(PLL_IDIV_BY2));
		note(0, 32'h20, 32'h0);
		step(SETTLE + 4);
		note(0, 32'h60, 32'h60);
		wr_ctl(SRC_PRI_PLL, 1'b0, 2'h0, 3'h0);
		note(0, 32'h20, 32'h0);
		note(2, 32'h7, 32'h5);
		step(SETTLE + 4);
		note(0, 32'h20, 32'h20);
		wr_ctl(SRC_FRC, 1'b0, 2'h0, 3'h0);
		note(0, 32'h60, 32'h0);
		$display("test pll done");
		wr_ctl(SRC_FRC, 1'b1, 2'h0, 3'h0);
		note(3, F_RUN | F_PIN, 32'h0);
		cfg.lso_hw_en <= 1'b1;
		wr_ctl(SRC_FRC, 1'b1, 2'h0, 3'h0);
		note(3, F_RUN | F_PIN, F_RUN | F_PIN);
		lso_edges(WARM - 1);
		note(0, 32'h0040_0002, 32'h2);
		lso_edges(1);
		step(4);
		note(0, 32'h0040_0002, 32'h0040_0002);
		note(3, F_RUN, F_RUN);
		$display("test low speed done");
		power_up_timer_done <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			cfg.fail_safe_en <= i[0];
			cfg.watchdog_en <= i[1];
			wr_ctl(i[2] ? SRC_LOW_POWER_RC : SRC_FRC, 1'b1, 2'h0, 3'h0);
			note(3, F_LOW_POWER_RC, (i != 0) ? F_LOW_POWER_RC : 32'h0);
		end
		$display("test low power rc done");
		repeat (4) begin
			rnd = xs();
			@(posedge core_clk);
			trim_wr <= 1'b1;
			trim_data <= rnd[TRIM_W-1:0];
			@(posedge core_clk);
			trim_wr <= 1'b0;
			step(1);
			note(4, 32'h3f, 32'(rnd[TRIM_W-1:0]));
		end
		$display("test trim done");
		for (int d = 0; d < 4; d++) begin
			wr_ctl(SRC_FRC, 1'b1, 2'(d), 3'h0);
			step(20);
			note(5, 32'hff, 32'd1 << d);
			pb_access <= 1'b1;
			note(3, F_STALL, 32'h0);
			step(1);
			note(3, F_STALL, (d != 0) ? F_STALL : 32'h0);
			step(1);
			pb_access <= 1'b0;
			note(0, 32'h0018_0000, 32'(d) << 19);
			step(10);
			// Busy must have cleared at the bus tick by now
			pb_access <= 1'b1;
			note(3, F_STALL, 32'h0);
			step(1);
			pb_access <= 1'b0;
		end
		$display("test bus divider done");
		// Mid-run reset with the regulator off and the power-up timer pending
		cfg.regulator_en <= 1'b0;
		power_up_timer_done <= 1'b0;
		srst <= 1'b1;
		step(4);
		srst <= 1'b0;
		note(0, 32'hffff_ffff, 32'h0);
		note(3, F_LOW_POWER_RC | F_RUN | F_STALL, F_LOW_POWER_RC);
		step(2);
		note(3, F_LOW_POWER_RC, F_LOW_POWER_RC);
		$display("test second reset done");
		end_of_test();
	end
endmodule : oscillator_status_and_bus_clock_bench
